/* rtl/ecpc_pkg.sv */
package ecpc_pkg;

  // register offsets (byte addresses, 64-bit registers)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DESC = 8'h08;
  localparam logic [7:0] REG_DEST = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_FAULT_ADDR = 8'h20;
  localparam logic [7:0] REG_MISC_SUP = 8'h28;
  localparam logic [7:0] REG_MAX_EXP = 8'h30;
  localparam logic [7:0] REG_ATTR_MASK = 8'h38;
  localparam logic [7:0] REG_FMASK_SUP = 8'h40;
  localparam logic [7:0] REG_NEXT_ID = 8'h48;
  localparam logic [7:0] REG_EXIT_INFO = 8'h50;
  localparam logic [7:0] REG_VIRT = 8'h58;
  localparam logic [7:0] REG_MAP_SEL = 8'h60;
  localparam logic [7:0] REG_MAP_INFO = 8'h68;
  localparam logic [7:0] REG_MAP_EVICT = 8'h70;
  localparam logic [7:0] REG_UPD_CNT = 8'h78;
  localparam logic [7:0] REG_MAP_EADDR = 8'h80;

  // reset values of software-visible configuration
  localparam logic [31:0] MISC_SUP_RST = 32'h0000_0001;
  localparam logic [15:0] MAX_EXP_RST = 16'h241f;
  localparam logic [63:0] ATTR_MASK_RST = 64'h0000_0000_0000_00f6;
  localparam logic [63:0] FMASK_SUP_RST = 64'h0000_0000_0000_0007;
  localparam logic [63:0] NEXT_ID_RST = 64'h0000_0000_0000_0001;

  // operation select and fault codes
  localparam logic [7:0] LEAF_CREATE = 8'h00;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_GP = 2'h1;
  localparam logic [1:0] FAULT_PF = 2'h2;
  localparam logic [1:0] FAULT_EXIT = 2'h3;
  localparam logic [15:0] POOL_CONFLICT_EXIT_REASON = 16'h003c;
  localparam logic [15:0] PAGE_CONFLICT_QUALIFICATION = 16'h0001;

  // alignment and size figures
  localparam int PAGE_SHIFT = 12;
  localparam int DESC_ALIGN_BITS = 5;
  localparam int SECI_ALIGN_BITS = 6;
  localparam logic [63:0] MIN_SIZE = 64'h0000_0000_0000_2000;
  localparam logic [63:0] NARROW_BASE_MASK = 64'hffff_ffff_0000_0000;
  localparam int CANON_MSB = 47;
  localparam int PAGE_WORDS = 512;

  // page descriptor word indices
  localparam logic [8:0] DESC_W_SRC = 9'h001;
  localparam logic [8:0] DESC_W_SECI = 9'h002;
  localparam logic [8:0] DESC_W_LAST = 9'h003;

  // security descriptor layout
  localparam logic [8:0] SECI_W_LAST = 9'h007;
  localparam int SECI_TYPE_LSB = 8;
  localparam logic [63:0] SECI_FLAGS_USED = 64'h0000_0000_0000_ff07;
  localparam logic [7:0] CONTROL_PAGE_TYPE = 8'h00;

  // control structure word indices
  localparam logic [8:0] CS_W_SIZE = 9'h000;
  localparam logic [8:0] CS_W_BASE = 9'h001;
  localparam logic [8:0] CS_W_SSA = 9'h002;
  localparam logic [8:0] CS_W_RSV_LO = 9'h003;
  localparam logic [8:0] CS_W_RSV_HI = 9'h005;
  localparam logic [8:0] CS_W_ATTR = 9'h006;
  localparam logic [8:0] CS_W_FMASK = 9'h007;
  localparam logic [8:0] CS_W_CFG_LO = 9'h008;
  localparam logic [8:0] CS_W_CFG_HI = 9'h00f;
  localparam logic [8:0] CS_W_CFGSVN = 9'h010;
  localparam logic [8:0] CS_W_ID = 9'h011;
  localparam logic [8:0] CS_W_VCHILD = 9'h012;
  localparam logic [8:0] CS_W_CTX = 9'h013;
  localparam logic [8:0] CS_W_VENDOR = 9'h014;
  localparam int ATTR_WIDE_BIT = 2;
  localparam int ATTR_KEYSEP_BIT = 7;

  // save-area sizing in bytes
  localparam logic [63:0] GENERAL_REGISTER_AREA_SIZE = 64'd184;
  localparam logic [63:0] XSAVE_LEGACY_BYTES = 64'd576;
  localparam logic [63:0] XSAVE_UPPER_BYTES = 64'd256;
  localparam logic [63:0] MISC_EXINFO_BYTES = 64'd16;

  localparam logic [63:0] MEASURE_TAG = 64'h0045_5441_4552_4345;

  typedef enum logic [6:0] {
    ECPC_IDLE = 7'b0000001,
    ECPC_RD_DESC = 7'b0000010,
    ECPC_RD_SECI = 7'b0000100,
    ECPC_CHK_DEST = 7'b0001000,
    ECPC_COPY = 7'b0010000,
    ECPC_VALIDATE = 7'b0100000,
    ECPC_FINAL = 7'b1000000
  } ecpc_st_t;

endpackage

/* rtl/ecpc_create.sv */
// Function
// - start this operation only when leaf index written is 00H
// - fault unless enclave size is at least 8192 and a power of two
// - fault when region base is not aligned to the enclave size
// - fault when page descriptor address is not 32-byte aligned
// - fault when destination address is not 4 KB aligned
// - page fault when destination does not fall inside the pool
// - fault on misaligned source page or security descriptor pointer
// - fault on nonzero unused descriptor linear address or control fields
// - fault on reserved security descriptor bits or wrong page type
// - fault when destination entry is busy and no exit applies
// - busy entry in guest with extensions enabled exits with conflict info
// - page fault when destination map entry is already valid
// - copy the whole 4 KB source page before checking its contents
// - fault unless feature mask has low two bits set and is legal
// - fault on unsupported misc selection bits, releasing the entry lock
// - fault when save frame pages times 4096 is below required area
// - fault on non-canonical wide base or high bits in narrow base
// - fault when size reaches two to the per-mode maximum exponent
// - fault on unsupported attributes or nonzero reserved structure words
// - fault on nonzero setup id or version without key separation bit
// - start measurement, zero vendor fields, hash tag block, bump counter
// - take identifier from next counter, zero child count, store context
// - on success mark map entry control type, cleared, and valid
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module ecpc_create #(
  parameter int POOL_PAGES = 16,
  parameter logic [63:0] POOL_BASE = 64'h0000_0000_8000_0000,
  localparam int SW = (POOL_PAGES > 1) ? $clog2(POOL_PAGES) : 1
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [63:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [63:0] reg_rdata_out,
  output logic mem_req_out,
  output logic [63:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [63:0] mem_rdata_in,
  input wire logic [POOL_PAGES-1:0] pool_busy_in,
  output logic pool_we_out,
  output logic [SW+8:0] pool_addr_out,
  output logic [63:0] pool_wdata_out,
  output logic [POOL_PAGES-1:0] dest_lock_out,
  output logic [POOL_PAGES-1:0] map_valid_out,
  output logic hash_init_out,
  output logic hash_update_out,
  output logic [511:0] hash_block_out,
  output logic busy_out,
  output logic done_out
);
  import ecpc_pkg::*;

  localparam logic [63:0] POOL_END = POOL_BASE + 64'(POOL_PAGES) * 64'd4096;

  if (POOL_PAGES < 1 || POOL_BASE[PAGE_SHIFT-1:0] != '0) begin : g_bad_param
    $error("pool must hold at least one page and start on a page boundary");
  end

  typedef struct packed {
    ecpc_st_t st;
    logic [8:0] idx;
    logic [63:0] desc_addr;
    logic [63:0] dest_addr;
    logic [63:0] src;
    logic [63:0] seci;
    logic lin_nz;
    logic seci_bad;
    logic [SW-1:0] slot;
    logic [63:0] size;
    logic [63:0] base;
    logic [31:0] ssa;
    logic [31:0] misc;
    logic [63:0] attr;
    logic [63:0] fmask;
    logic cfg_nz;
    logic rsv_nz;
    logic [1:0] fault;
    logic [63:0] fault_addr;
    logic [63:0] exit_info;
    logic done;
    logic [31:0] misc_sup;
    logic [15:0] max_exp;
    logic [63:0] attr_mask;
    logic [63:0] fmask_sup;
    logic [1:0] virt;
    logic [63:0] next_id;
    logic [63:0] upd_cnt;
    logic [SW-1:0] map_sel;
    logic [POOL_PAGES-1:0] map_valid;
    logic [POOL_PAGES-1:0][7:0] map_type;
    logic [POOL_PAGES-1:0][6:0] map_attr;
    logic [POOL_PAGES-1:0][63:0] map_eaddr;
    logic [POOL_PAGES-1:0] lock;
    logic [63:0] mem_addr;
    logic pool_we;
    logic [SW+8:0] pool_addr;
    logic [63:0] pool_wdata;
    logic hinit;
    logic hupd;
    logic [511:0] hblock;
    logic [63:0] rdata;
  } ecpc_state_t;

  ecpc_state_t q;
  ecpc_state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic low_bits_set(input logic [63:0] a, input int n);
    logic [63:0] m;
    m = (64'h1 << n) - 64'h1;
    return (a & m) != 64'h0;
  endfunction

  function automatic logic in_pool(input logic [63:0] a);
    return (a >= POOL_BASE) && (a < POOL_END);
  endfunction

  function automatic logic [SW-1:0] slot_of(input logic [63:0] a);
    logic [63:0] off;
    off = (a - POOL_BASE) >> PAGE_SHIFT;
    return off[SW-1:0];
  endfunction

  function automatic logic reaches_exp(input logic [63:0] sz, input logic [7:0] e);
    return (e < 8'd64) && (sz >= (64'h1 << e));
  endfunction

  function automatic logic [63:0] save_area_required(input logic [63:0] xf,
                                                     input logic [31:0] ms);
    logic [63:0] r;
    r = XSAVE_LEGACY_BYTES + GENERAL_REGISTER_AREA_SIZE;
    if (xf[2]) begin
      r = r + XSAVE_UPPER_BYTES;
    end
    if (ms[0]) begin
      r = r + MISC_EXINFO_BYTES;
    end
    return r;
  endfunction

  function automatic ecpc_state_t finish(input ecpc_state_t s, input logic [1:0] code,
                                         input logic [63:0] addr);
    ecpc_state_t r;
    r = s;
    r.fault = code;
    r.fault_addr = addr;
    r.lock[s.slot] = 1'b0;
    r.st = ECPC_IDLE;
    r.done = 1'b1;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic start;
  logic busy_hit;
  logic [63:0] rd_mux;
  logic wide;
  logic [63:0] need;

  always_comb begin
    start = reg_wr_in && (reg_addr_in == REG_CMD) && (q.st == ECPC_IDLE) &&
            (reg_wdata_in[7:0] == LEAF_CREATE);
    busy_hit = pool_busy_in[q.slot];
    wide = q.attr[ATTR_WIDE_BIT];
    need = save_area_required(q.fmask, q.misc);

    case (reg_addr_in)
      REG_DESC: rd_mux = q.desc_addr;
      REG_DEST: rd_mux = q.dest_addr;
      REG_STATUS: rd_mux = {61'h0, q.fault, q.st != ECPC_IDLE};
      REG_FAULT_ADDR: rd_mux = q.fault_addr;
      REG_MISC_SUP: rd_mux = {32'h0, q.misc_sup};
      REG_MAX_EXP: rd_mux = {48'h0, q.max_exp};
      REG_ATTR_MASK: rd_mux = q.attr_mask;
      REG_FMASK_SUP: rd_mux = q.fmask_sup;
      REG_NEXT_ID: rd_mux = q.next_id;
      REG_EXIT_INFO: rd_mux = q.exit_info;
      REG_VIRT: rd_mux = {62'h0, q.virt};
      REG_MAP_SEL: rd_mux = 64'(q.map_sel);
      REG_MAP_INFO: rd_mux = {48'h0, q.map_valid[q.map_sel], q.map_type[q.map_sel],
                              q.map_attr[q.map_sel]};
      REG_MAP_EADDR: rd_mux = q.map_eaddr[q.map_sel];
      REG_UPD_CNT: rd_mux = q.upd_cnt;
      default: rd_mux = 64'h0;
    endcase

    d = q;
    d.done = 1'b0;
    d.pool_we = 1'b0;
    d.hinit = 1'b0;
    d.hupd = 1'b0;
    d.rdata = reg_rd_in ? rd_mux : 64'h0;

    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_DESC: if (q.st == ECPC_IDLE) d.desc_addr = reg_wdata_in;
        REG_DEST: if (q.st == ECPC_IDLE) d.dest_addr = reg_wdata_in;
        REG_MISC_SUP: d.misc_sup = reg_wdata_in[31:0];
        REG_MAX_EXP: d.max_exp = reg_wdata_in[15:0];
        REG_ATTR_MASK: d.attr_mask = reg_wdata_in;
        REG_FMASK_SUP: d.fmask_sup = reg_wdata_in;
        REG_VIRT: d.virt = reg_wdata_in[1:0];
        REG_MAP_SEL: d.map_sel = reg_wdata_in[SW-1:0];
        REG_MAP_EVICT: begin
          if (int'(reg_wdata_in[SW-1:0]) < POOL_PAGES &&
              !q.lock[reg_wdata_in[SW-1:0]]) begin
            d.map_valid[reg_wdata_in[SW-1:0]] = 1'b0;
          end
        end
        default: ;
      endcase
    end

    case (q.st)
      ECPC_IDLE: begin
        if (start) begin
          d.fault = FAULT_NONE;
          d.exit_info = 64'h0;
          d.slot = slot_of(q.dest_addr);
          if (low_bits_set(q.desc_addr, DESC_ALIGN_BITS)) begin
            d = finish(d, FAULT_GP, q.desc_addr);
          end else if (low_bits_set(q.dest_addr, PAGE_SHIFT)) begin
            d = finish(d, FAULT_GP, q.dest_addr);
          end else if (!in_pool(q.dest_addr)) begin
            d = finish(d, FAULT_PF, q.dest_addr);
          end else begin
            d.st = ECPC_RD_DESC;
            d.idx = 9'h0;
            d.mem_addr = q.desc_addr;
          end
        end
      end
      ECPC_RD_DESC: begin
        if (mem_ack_in) begin
          d.idx = 9'(q.idx + 9'h1);
          d.mem_addr = q.mem_addr + 64'd8;
          case (q.idx)
            9'h0: d.lin_nz = mem_rdata_in != 64'h0;
            DESC_W_SRC: d.src = mem_rdata_in;
            DESC_W_SECI: d.seci = mem_rdata_in;
            default: ;
          endcase
          if (q.idx == DESC_W_LAST) begin
            if (low_bits_set(q.src, PAGE_SHIFT) ||
                low_bits_set(q.seci, SECI_ALIGN_BITS)) begin
              d = finish(d, FAULT_GP, q.desc_addr);
            end else if (q.lin_nz || mem_rdata_in != 64'h0) begin
              d = finish(d, FAULT_GP, q.desc_addr);
            end else begin
              d.st = ECPC_RD_SECI;
              d.idx = 9'h0;
              d.mem_addr = q.seci;
              d.seci_bad = 1'b0;
            end
          end
        end
      end
      ECPC_RD_SECI: begin
        if (mem_ack_in) begin
          d.idx = 9'(q.idx + 9'h1);
          d.mem_addr = q.mem_addr + 64'd8;
          if (q.idx == 9'h0) begin
            d.seci_bad = ((mem_rdata_in & ~SECI_FLAGS_USED) != 64'h0) ||
                         (mem_rdata_in[SECI_TYPE_LSB +: 8] != CONTROL_PAGE_TYPE);
          end else begin
            d.seci_bad = q.seci_bad || (mem_rdata_in != 64'h0);
          end
          if (q.idx == SECI_W_LAST) begin
            if (d.seci_bad) begin
              d = finish(d, FAULT_GP, q.seci);
            end else begin
              d.st = ECPC_CHK_DEST;
            end
          end
        end
      end
      ECPC_CHK_DEST: begin
        if (busy_hit && q.virt == 2'b11) begin
          d = finish(d, FAULT_EXIT, q.dest_addr);
          d.exit_info = {16'h0, 16'h0, PAGE_CONFLICT_QUALIFICATION,
                         POOL_CONFLICT_EXIT_REASON};
        end else if (busy_hit) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if (q.map_valid[q.slot]) begin
          d = finish(d, FAULT_PF, q.dest_addr);
        end else begin
          d.lock[q.slot] = 1'b1;
          d.st = ECPC_COPY;
          d.idx = 9'h0;
          d.mem_addr = q.src;
          d.cfg_nz = 1'b0;
          d.rsv_nz = 1'b0;
        end
      end
      ECPC_COPY: begin
        if (mem_ack_in) begin
          d.pool_we = 1'b1;
          d.pool_addr = {q.slot, q.idx};
          d.pool_wdata = mem_rdata_in;
          d.idx = 9'(q.idx + 9'h1);
          d.mem_addr = q.mem_addr + 64'd8;
          case (q.idx)
            CS_W_SIZE: d.size = mem_rdata_in;
            CS_W_BASE: d.base = mem_rdata_in;
            CS_W_SSA: begin
              d.ssa = mem_rdata_in[31:0];
              d.misc = mem_rdata_in[63:32];
            end
            CS_W_ATTR: d.attr = mem_rdata_in;
            CS_W_FMASK: d.fmask = mem_rdata_in;
            CS_W_CFGSVN: begin
              d.cfg_nz = q.cfg_nz || (mem_rdata_in[15:0] != 16'h0);
              d.rsv_nz = q.rsv_nz || (mem_rdata_in[63:16] != 48'h0);
            end
            default: begin
              if (q.idx >= CS_W_RSV_LO && q.idx <= CS_W_RSV_HI) begin
                d.rsv_nz = q.rsv_nz || (mem_rdata_in != 64'h0);
              end
              if (q.idx >= CS_W_CFG_LO && q.idx <= CS_W_CFG_HI) begin
                d.cfg_nz = q.cfg_nz || (mem_rdata_in != 64'h0);
              end
            end
          endcase
          if (q.idx == 9'(PAGE_WORDS - 1)) begin
            d.st = ECPC_VALIDATE;
          end
        end
      end
      ECPC_VALIDATE: begin
        if (q.fmask[1:0] != 2'b11) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if ((q.fmask & ~q.fmask_sup) != 64'h0 || (q.fmask[2] && !q.fmask[1])) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if ((q.misc & ~q.misc_sup) != 32'h0) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if ({20'h0, q.ssa, 12'h0} < need) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if (wide && q.base[63:CANON_MSB] != '0 && q.base[63:CANON_MSB] != '1) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if (!wide && (q.base & NARROW_BASE_MASK) != 64'h0) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if (reaches_exp(q.size, wide ? q.max_exp[15:8] : q.max_exp[7:0])) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if (q.size < MIN_SIZE || $countones(q.size) > 1) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if ((q.base & (q.size - 64'h1)) != 64'h0) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if ((q.attr & ~q.attr_mask) != 64'h0 || q.rsv_nz) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else if (q.cfg_nz && !q.attr[ATTR_KEYSEP_BIT]) begin
          d = finish(d, FAULT_GP, q.dest_addr);
        end else begin
          d.st = ECPC_FINAL;
          d.idx = 9'h0;
          d.hinit = 1'b1;
          d.upd_cnt = 64'h0;
          d.hblock = {352'h0, q.size, q.ssa, MEASURE_TAG};
        end
      end
      ECPC_FINAL: begin
        d.idx = 9'(q.idx + 9'h1);
        d.pool_we = 1'b1;
        case (q.idx[1:0])
          2'h0: begin
            d.hupd = 1'b1;
            d.upd_cnt = q.upd_cnt + 64'h1;
            d.pool_addr = {q.slot, CS_W_ID};
            d.pool_wdata = q.next_id;
            d.next_id = q.next_id + 64'h1;
          end
          2'h1: begin
            d.pool_addr = {q.slot, CS_W_VCHILD};
            d.pool_wdata = 64'h0;
          end
          2'h2: begin
            d.pool_addr = {q.slot, CS_W_CTX};
            d.pool_wdata = q.dest_addr;
          end
          default: begin
            d.pool_addr = {q.slot, CS_W_VENDOR};
            d.pool_wdata = 64'h0;
            d.map_type[q.slot] = CONTROL_PAGE_TYPE;
            d.map_eaddr[q.slot] = 64'h0;
            d.map_attr[q.slot] = 7'h0;
            d.map_valid[q.slot] = 1'b1;
            d = finish(d, FAULT_NONE, 64'h0);
          end
        endcase
      end
      default: d.st = ECPC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= '0;
      q.st <= ECPC_IDLE;
      q.misc_sup <= MISC_SUP_RST;
      q.max_exp <= MAX_EXP_RST;
      q.attr_mask <= ATTR_MASK_RST;
      q.fmask_sup <= FMASK_SUP_RST;
      q.next_id <= NEXT_ID_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_out = q.rdata;
  assign mem_req_out = (q.st == ECPC_RD_DESC) || (q.st == ECPC_RD_SECI) ||
                       (q.st == ECPC_COPY);
  assign mem_addr_out = q.mem_addr;
  assign pool_we_out = q.pool_we;
  assign pool_addr_out = q.pool_addr;
  assign pool_wdata_out = q.pool_wdata;
  assign dest_lock_out = q.lock;
  assign map_valid_out = q.map_valid;
  assign hash_init_out = q.hinit;
  assign hash_update_out = q.hupd;
  assign hash_block_out = q.hblock;
  assign busy_out = q.st != ECPC_IDLE;
  assign done_out = q.done;

endmodule

`default_nettype wire

/* dv/ecpc_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module ecpc_chk #(
  parameter int POOL_PAGES = 16
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic mem_req_out,
  input wire logic [63:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic pool_we_out,
  input wire logic [POOL_PAGES-1:0] dest_lock_out,
  input wire logic [POOL_PAGES-1:0] map_valid_out,
  input wire logic hash_init_out,
  input wire logic hash_update_out,
  input wire logic [511:0] hash_block_out,
  input wire logic busy_out,
  input wire logic done_out
);
  import ecpc_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence s_hash;
    hash_init_out ##1 hash_update_out;
  endsequence
  sequence s_finish;
    hash_update_out ##3 done_out;
  endsequence
  a_hash_order: assert property (hash_init_out |-> s_hash)
    else $error("hash update missing after init");
  a_hash_tag: assert property (hash_update_out |-> hash_block_out[63:0] == MEASURE_TAG
    && hash_block_out[511:160] == '0) else $error("hash block malformed");
  a_hash_done: assert property (hash_update_out |-> s_finish)
    else $error("done not three cycles after hash update");
  a_map_on_done: assert property ((map_valid_out & ~$past(map_valid_out)) != '0 |-> done_out)
    else $error("map entry validated outside completion");
  a_fault_keep: assert property (done_out && !$past(hash_update_out, 3) |-> $stable(map_valid_out))
    else $error("faulting operation changed the map");
  a_we_locked: assert property (pool_we_out |-> $past(dest_lock_out) != '0)
    else $error("pool written without a locked slot");
  a_lock_single: assert property ($onehot0(dest_lock_out))
    else $error("more than one slot locked");
  a_lock_free: assert property (done_out |-> dest_lock_out == '0 && !busy_out)
    else $error("lock or busy held at completion");
  a_addr_held: assert property (mem_req_out && !mem_ack_in ##1 mem_req_out |-> $stable(mem_addr_out))
    else $error("read address moved without an answer");
endmodule
bind ecpc_create ecpc_chk #(.POOL_PAGES(POOL_PAGES)) chk_u (.clk_in(clk_in), .srst_in(srst_in),
  .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in),
  .pool_we_out(pool_we_out), .dest_lock_out(dest_lock_out), .map_valid_out(map_valid_out),
  .hash_init_out(hash_init_out), .hash_update_out(hash_update_out),
  .hash_block_out(hash_block_out), .busy_out(busy_out), .done_out(done_out));
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ecpc_pkg::*;
  localparam logic [63:0] PB = 64'h0000_0000_8000_0000;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [63:0] reg_wdata_in = 64'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic mem_ack_in = 1'b0;
  logic [63:0] mem_rdata_in = 64'h0;
  logic [15:0] pool_busy_in = 16'h0;
  logic [63:0] reg_rdata_out, mem_addr_out, pool_wdata_out;
  logic mem_req_out, pool_we_out, hash_init_out, hash_update_out, busy_out, done_out;
  logic [12:0] pool_addr_out;
  logic [15:0] dest_lock_out, map_valid_out;
  logic [511:0] hash_block_out;
  logic [63:0] fmask_v = 64'h3, size_v = 64'h2000, w_base = 64'h0, w_id = 64'h0;
  logic [63:0] w_ctx = 64'h0, pk_a = 64'h1, pk_d = 64'h0;
  int failures = 0;
  int n_checks = 0;
  always #10 clk_in = ~clk_in;
  ecpc_create #(.POOL_PAGES(16), .POOL_BASE(PB)) dut_u (.clk_in(clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
    .pool_busy_in(pool_busy_in), .pool_we_out(pool_we_out), .pool_addr_out(pool_addr_out),
    .pool_wdata_out(pool_wdata_out), .dest_lock_out(dest_lock_out),
    .map_valid_out(map_valid_out), .hash_init_out(hash_init_out),
    .hash_update_out(hash_update_out), .hash_block_out(hash_block_out),
    .busy_out(busy_out), .done_out(done_out));
  function automatic logic [63:0] mword(input logic [63:0] a);
    case (a)
      pk_a: mword = pk_d;
      64'h108: mword = 64'h1000;
      64'h110: mword = 64'h2040;
      64'h1000: mword = size_v;
      64'h1008: mword = 64'h4000;
      64'h1010: mword = 64'h1;
      64'h1038: mword = fmask_v;
      default: mword = 64'h0;
    endcase
  endfunction
  // memory answers every other cycle; data is scrambled when not answering
  always @(posedge clk_in) begin
    mem_ack_in <= mem_req_out && !mem_ack_in;
    mem_rdata_in <= (mem_req_out && !mem_ack_in) ? mword(mem_addr_out) : ~mem_rdata_in;
    if (pool_we_out && pool_addr_out[8:0] == 9'h001) w_base <= pool_wdata_out;
    if (pool_we_out && pool_addr_out[8:0] == 9'h011) w_id <= pool_wdata_out;
    if (pool_we_out && pool_addr_out[8:0] == 9'h013) w_ctx <= pool_wdata_out;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [63:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk(reg_rdata_out, exp);
  endtask
  task automatic op(input logic [63:0] desc, input logic [63:0] dest, input logic [1:0] code);
    wr(REG_DESC, desc);
    wr(REG_DEST, dest);
    wr(REG_CMD, {56'h0, LEAF_CREATE});
    repeat (1500) begin
      @(negedge clk_in);
      if (done_out === 1'b1) break;
    end
    rdchk(REG_STATUS, {61'h0, code, 1'b0});
  endtask
  // one bad word in memory, everything else legal
  task automatic bad(input logic [63:0] a, input logic [63:0] v);
    pk_a = a;
    pk_d = v;
    op(64'h100, PB + 64'h4000, FAULT_GP);
    pk_a = 64'h1;
  endtask
  task automatic t_fields;
    bad(64'h108, 64'h1008);
    bad(64'h118, 64'h1);
    bad(64'h2040, 64'h100);
    bad(64'h1010, 64'h2_0000_0001);
    bad(64'h1010, 64'h0);
    bad(64'h1008, 64'h1_0000_0000);
    bad(64'h1000, 64'h8000_0000);
    bad(64'h1030, 64'h1);
    bad(64'h1040, 64'h1);
  endtask
  task automatic t_reset;
    rdchk(REG_MISC_SUP, {32'h0, MISC_SUP_RST});
    rdchk(REG_MAX_EXP, {48'h0, MAX_EXP_RST});
    rdchk(REG_NEXT_ID, NEXT_ID_RST);
    rdchk(8'h88, 64'h0);
  endtask
  task automatic t_early;
    wr(REG_CMD, 64'h1);
    rdchk(REG_STATUS, 64'h0);
    op(64'h104, PB, FAULT_GP);
    op(64'h100, PB + 64'h800, FAULT_GP);
    op(64'h100, PB + 64'h10000, FAULT_PF);
    op(64'h100, PB - 64'h1000, FAULT_PF);
  endtask
  task automatic t_create;
    op(64'h100, PB + 64'h2000, FAULT_NONE);
    chk({48'h0, map_valid_out}, 64'h4);
    chk(hash_block_out[63:0], MEASURE_TAG);
    chk({32'h0, hash_block_out[95:64]}, 64'h1);
    chk(hash_block_out[159:96], size_v);
    chk(w_base, 64'h4000);
    chk(w_id, NEXT_ID_RST);
    chk(w_ctx, PB + 64'h2000);
    rdchk(REG_UPD_CNT, 64'h1);
    rdchk(REG_NEXT_ID, NEXT_ID_RST + 64'h1);
    wr(REG_MAP_SEL, 64'h2);
    rdchk(REG_MAP_INFO, 64'h8000);
  endtask
  task automatic t_refuse;
    op(64'h100, PB + 64'h2000, FAULT_PF);
    @(posedge clk_in);
    pool_busy_in <= 16'h0008;
    wr(REG_VIRT, 64'h1);
    op(64'h100, PB + 64'h3000, FAULT_GP);
    wr(REG_VIRT, 64'h3);
    op(64'h100, PB + 64'h3000, FAULT_EXIT);
    rdchk(REG_EXIT_INFO, 64'h0000_0000_0001_003c);
    rdchk(REG_FAULT_ADDR, PB + 64'h3000);
    @(posedge clk_in);
    pool_busy_in <= 16'h0000;
    fmask_v = 64'h1;
    op(64'h100, PB + 64'h4000, FAULT_GP);
    fmask_v = 64'h3;
    size_v = 64'h3000;
    op(64'h100, PB + 64'h4000, FAULT_GP);
    size_v = 64'h8000;
    op(64'h100, PB + 64'h4000, FAULT_GP);
    chk({48'h0, map_valid_out}, 64'h4);
    rdchk(REG_NEXT_ID, NEXT_ID_RST + 64'h1);
  endtask
  task automatic print_verdict;
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_early();
    t_create();
    t_fields();
    t_refuse();
    print_verdict();
  end
  initial begin
    #600000;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
